// File: adc_bus_conversion_control.sv
// Bus host that runs conversions on the half-flash converter
`timescale 1ns/1ps
module adc_bus_conversion_control (
   input  wire logic                              sys_clk,   // 40 MHz clock
   input  wire logic                              rst_n,     // Sync reset, low active
   input  wire logic                              startReq,  // Request a conversion
   input  wire logic                              wrRdMode,  // 1 write-then-read, 0 read-only
   input  wire logic                              fastRead,  // Read before timeout
   output logic                                   busy,      // Conversion in progress
   output adc_host_pkg::result_t                  result,    // Last result
   output logic                                   resultVld, // One-cycle result pulse
   output adc_host_pkg::bus_ctl_t                 pins,      // Converter control pins
   input  wire logic [adc_host_pkg::DATA_W-1:0]   resultBus, // Converter data pins
   input  wire logic                              rdyIn,     // Ready pin level
   input  wire logic                              doneN      // Done flag pin, low active
);
   typedef enum logic [2:0] {IDLE, WR_LOW, WAIT_DONE, RD_LOW, RD_WAIT, RECOVER} state_t;

   state_t                          state;
   state_t                          next_state;
   logic [adc_host_pkg::CNT_W-1:0]  cnt;
   logic [adc_host_pkg::CNT_W-1:0]  next_cnt;
   logic                            fastReg;
   logic                            next_fastReg;
   adc_host_pkg::bus_ctl_t          next_pins;
   adc_host_pkg::result_t           next_result;
   logic                            next_resultVld;
   logic [adc_host_pkg::DATA_W+1:0] syncIn;

   // Pin inputs pass two flops before any logic reads them
   sync2 #(.W(adc_host_pkg::DATA_W + 2)) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .din     ({resultBus, rdyIn, doneN}),
      .dout    (syncIn)
   );

   wire logic [adc_host_pkg::DATA_W-1:0] dataS  = syncIn[adc_host_pkg::DATA_W+1:2]; // RULE13
   wire logic                            rdyS   = syncIn[1];
   wire logic                            doneNS = syncIn[0];

   assign busy = (state != IDLE);

   always_comb
   begin
      next_state     = state;
      next_cnt       = cnt + 1'b1;
      next_fastReg   = fastReg;
      next_pins      = pins;
      next_result    = result;
      next_resultVld = 1'b0;
      unique case (state)
         IDLE:
         begin
            next_cnt = '0;
            if (startReq)
            begin
               next_fastReg   = fastRead;
               next_pins.mode = wrRdMode; // RULE2
               next_pins.csN  = 1'b0; // RULE14
               if (wrRdMode)
               begin
                  next_pins.wrN = 1'b0; // RULE4
                  next_state    = WR_LOW;
               end
               else
               begin
                  next_pins.rdN = 1'b0; // RULE10
                  next_state    = RD_WAIT;
               end
            end
         end
         WR_LOW:
            if (cnt == adc_host_pkg::CNT_W'(adc_host_pkg::WR_LOW_CYC - 1))
            begin
               next_pins.wrN = 1'b1;
               next_cnt      = '0;
               next_state    = WAIT_DONE;
            end
         WAIT_DONE:
            // Done flag read only once the start strobe has surely cleared a stale level
            if (fastReg && cnt == adc_host_pkg::CNT_W'(adc_host_pkg::ACCESS_CYC))
            begin
               next_pins.rdN = 1'b0; // RULE6
               next_cnt      = '0;
               next_state    = RD_LOW;
            end
            else if ((!doneNS && cnt > adc_host_pkg::CNT_W'(adc_host_pkg::DONE_CLR_CYC + 2)) ||
                     cnt == adc_host_pkg::CNT_W'(adc_host_pkg::TIMEOUT_CYC + 4))
            begin
               next_pins.rdN = 1'b0; // RULE5 RULE1
               next_cnt      = '0;
               next_state    = RD_LOW;
            end
         RD_LOW:
            // Wait access time plus sync delay before sampling
            // Early read waits here until the done flag falls
            if (cnt >= adc_host_pkg::CNT_W'(adc_host_pkg::ACCESS_CYC + 2) &&
                (!fastReg || !doneNS))
            begin
               next_result.data     = dataS; // RULE7
               next_result.timedOut = 1'b0;
               next_resultVld       = 1'b1;
               next_pins.rdN        = 1'b1; // RULE15 RULE16
               next_pins.csN        = 1'b1;
               next_cnt             = '0;
               next_state           = RECOVER;
            end
            else if (cnt == adc_host_pkg::CNT_W'(adc_host_pkg::RD_MAX_CYC))
            begin
               next_result.timedOut = 1'b1;
               next_resultVld       = 1'b1;
               next_pins.rdN        = 1'b1;
               next_pins.csN        = 1'b1;
               next_cnt             = '0;
               next_state           = RECOVER;
            end
         RD_WAIT:
            // Ready released and done low mark completion; bus then valid
            // Ready must be pulled low first, so a power-up low done flag is ignored
            if (rdyS && !doneNS && // RULE8 RULE9 RULE11 RULE12
                cnt > adc_host_pkg::CNT_W'(adc_host_pkg::RDY_DLY_CYC + 2)) // RULE1
            begin
               next_cnt   = '0;
               next_state = RD_LOW;
            end
            else if (cnt == adc_host_pkg::CNT_W'(adc_host_pkg::RD_MAX_CYC))
            begin
               next_result.timedOut = 1'b1;
               next_resultVld       = 1'b1;
               next_pins.rdN        = 1'b1;
               next_pins.csN        = 1'b1;
               next_cnt             = '0;
               next_state           = RECOVER;
            end
         RECOVER:
            if (cnt == adc_host_pkg::CNT_W'(adc_host_pkg::RECOVER_CYC))
               next_state = IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state     <= IDLE;
         cnt       <= '0;
         fastReg   <= 1'b0;
         pins      <= '{csN: 1'b1, wrN: 1'b1, rdN: 1'b1, mode: 1'b0}; // RULE3
         result    <= '0;
         resultVld <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         cnt       <= next_cnt;
         fastReg   <= next_fastReg;
         pins      <= next_pins;
         result    <= next_result;
         resultVld <= next_resultVld;
      end
   end
endmodule

// File: adc_bus_conversion_control_asserts.sv
// Port checker for the converter bus host
`timescale 1ns/1ps
module adc_bus_conversion_control_asserts (
   input wire logic             sys_clk,   // Clock
   input wire logic             rst_n,     // Sync reset
   input wire logic             startReq,  // Request
   input wire logic             wrRdMode,  // Mode asked
   input wire logic             busy,      // Busy
   input wire logic             resultVld, // Result pulse
   input adc_host_pkg::bus_ctl_t pins      // Pins
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_take_mode: assert property (startReq && !busy |=> !pins.csN && pins.mode == $past(wrRdMode))
      else $error("select or mode wrong after request");
   a_wr_width: assert property ($fell(pins.wrN) |-> !pins.csN && pins.mode ##1 !pins.wrN [*8])
      else $error("start strobe too short or unselected");
   a_rd_select: assert property (!pins.rdN |-> !pins.csN)
      else $error("read strobe low without select");
   a_wr_select: assert property (!pins.wrN |-> !pins.csN)
      else $error("start strobe low without select");
   a_early_read: assert property ($fell(pins.rdN) && pins.mode |-> pins.wrN && $past(pins.wrN, 4))
      else $error("read strobe before start strobe ended");
   a_vld_release: assert property ($rose(resultVld) |-> ##[0:1] pins.csN && pins.rdN)
      else $error("strobes not released with result");
   a_idle_pins: assert property (!busy |-> pins.csN && pins.wrN && pins.rdN)
      else $error("strobe active while idle");
   a_vld_pulse: assert property (resultVld |=> !resultVld && busy)
      else $error("result pulse longer than one cycle");
   c_rd: cover property (startReq && !busy && !wrRdMode);
   c_wr: cover property (startReq && !busy && wrRdMode);
   c_vld: cover property (resultVld);
endmodule
bind adc_bus_conversion_control adc_bus_conversion_control_asserts u_chk (.sys_clk(sys_clk),
   .rst_n(rst_n), .startReq(startReq), .wrRdMode(wrRdMode), .busy(busy),
   .resultVld(resultVld), .pins(pins));

// File: adc_bus_conversion_control_tb_top.sv
// Self-checking bench for the converter bus host
`timescale 1ns/1ps
module adc_bus_conversion_control_tb_top;
   logic                   sys_clk, rst_n, startReq, wrRdMode, fastRead, slow;
   logic                   busy, resultVld, rdyLow, doneN;
   logic [7:0]             sample, busLine;
   adc_host_pkg::bus_ctl_t pins;
   adc_host_pkg::result_t  result;
   logic [8:0]             expQ[$];
   logic [31:0]            seed = 32'd48893;
   int                     fail_count = 0;
   int                     checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   adc_bus_conversion_control dut (.sys_clk(sys_clk), .rst_n(rst_n), .startReq(startReq),
      .wrRdMode(wrRdMode), .fastRead(fastRead), .busy(busy), .result(result),
      .resultVld(resultVld), .pins(pins), .resultBus(busLine), .rdyIn(~rdyLow), .doneN(doneN));
   adc_conv_model conv (.sys_clk(sys_clk), .pins(pins), .sample(sample), .slow(slow),
      .busOut(busLine), .rdyLow(rdyLow), .doneN(doneN));
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic compare(input logic [8:0] got, input logic [8:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic convert(input logic [2:0] sel);
      logic [31:0] v;
      int          n;
      v = xorshift();
      n = 0;
      @(posedge sys_clk);
      {slow, fastRead, wrRdMode} <= sel;
      sample <= v[7:0];
      startReq <= 1'b1;
      expQ.push_back({1'b0, v[7:0]});
      @(posedge sys_clk);
      startReq <= 1'b0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (busy !== 1'b0 && n < 400);
      compare({8'h00, busy}, 9'h000);
      compare({5'h00, pins}, {5'h00, 3'h7, sel[0]});
      compare({8'h00, doneN}, 9'h001);
      $display("test done sel=%0d", sel);
   endtask
   // Results are registered, so the edge sees the pulse and its data together
   always @(posedge sys_clk)
      if (resultVld === 1'b1)
         compare(result, expQ.pop_front());
   initial
   begin
      #150000;
      fail_count++;
      stop_test();
   end
   initial
   begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      {startReq, wrRdMode, fastRead, slow} = 4'h0;
      sample = 8'h00;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++)
         convert(i[2:0]);
      stop_test();
   end
endmodule

// File: adc_conv_model.sv
// Behavioural model of the half-flash converter pins
`timescale 1ns/1ps
module adc_conv_model (
   input wire logic             sys_clk, // Timing base
   input adc_host_pkg::bus_ctl_t pins,    // Host pins
   input wire logic [7:0]       sample,  // Analog value
   input wire logic             slow,    // Long conversion in read-only mode; write-then-read timing ignores it
   output logic [7:0]           busOut,  // Resolved data lines
   output logic                 rdyLow,  // Ready pulled low
   output logic                 doneN    // Done flag
);
   adc_host_pkg::bus_ctl_t prev = 4'hf;
   logic [7:0]  latchQ = 8'h5a;
   logic        conv = 1'b0;
   int          cnt = 0;
   wire         rdMode = (pins.mode !== 1'b1);
   wire         drive = !pins.csN && !pins.rdN && !conv;
   // Released lines show the inverse so stale data cannot pass
   assign busOut = drive ? latchQ : ~latchQ;
   initial rdyLow = 1'b0;
   initial doneN = 1'b0;
   always @(posedge sys_clk)
   begin
      prev <= pins;
      if (conv)
         cnt <= cnt - 1;
      if (!pins.csN && prev.csN && rdMode)
         rdyLow <= 1'b1;
      if (!pins.csN && rdMode && prev.rdN && !pins.rdN)
      begin
         conv <= 1'b1;
         cnt <= slow ? 60 : 24;
      end
      if (!pins.csN && !rdMode && prev.wrN && !pins.wrN)
      begin
         conv <= 1'b1;
         cnt <= 1000;
      end
      if (conv && !rdMode && !prev.wrN && pins.wrN)
      begin
         cnt <= 32;
         doneN <= 1'b1;
      end
      if (conv && !rdMode && prev.rdN && !pins.rdN && cnt > 10)
         cnt <= 10;
      if (conv && cnt == 1)
      begin
         latchQ <= sample;
         conv <= 1'b0;
         doneN <= 1'b0;
         rdyLow <= 1'b0;
      end
      if ((!prev.rdN && pins.rdN) || (!prev.csN && pins.csN))
         doneN <= 1'b1;
   end
endmodule

// File: adc_host_pkg.sv
// Constants and carriers for the converter bus host
// Behaviour
// [RULE1] Host ignores the done flag after power-up until its first conversion ends; here it ignores it for a fixed cycle count after every start.
// [RULE2] Converter mode pin low selects read-only, high selects write-then-read.
// [RULE3] An open mode pin reads low, so read-only is the default.
// [RULE4] Write-then-read: host pulses start strobe low with select low to begin.
// [RULE5] Without early read, result latches about 800 ns after start strobe rises.
// [RULE6] Host may assert read early; result then latches after read falls.
// [RULE7] Write-then-read: result bus is driven while select and read are low.
// [RULE8] Ready is open drain, pulled low after select falls in read-only mode.
// [RULE9] Read-only: ready releases when the result enters the output latch.
// [RULE10] Read-only: host starts a conversion by driving read low with select low.
// [RULE11] Read-only: bus stays high impedance until conversion completes, read low.
// [RULE12] Read-only: ready release and done flag low mark completion together.
// [RULE13] Result bus is 8 bits, bit 0 least significant.
// [RULE14] Strobes count only while chip select is low.
// [RULE15] Done flag low when result latched; cleared by read or select rising.
// [RULE16] Result bus returns to high impedance when read or select rises.
package adc_host_pkg;

   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned DATA_W        = 8;
   // Start strobe low width, done timeout, read access time, read limit and recovery between conversions
   localparam int unsigned WR_LOW_NS     = 600;
   localparam int unsigned TIMEOUT_NS    = 800;
   localparam int unsigned ACCESS_NS     = 150;
   localparam int unsigned RD_MAX_NS     = 2500;
   localparam int unsigned RECOVER_NS    = 500;
   // Worst delays: done cleared after start strobe rises, ready pulled low after select
   localparam int unsigned DONE_CLR_NS   = 270;
   localparam int unsigned RDY_DLY_NS    = 100;
   localparam int unsigned WR_LOW_CYC    = (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMEOUT_CYC   = (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RD_MAX_CYC    = (RD_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RECOVER_CYC   = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DONE_CLR_CYC  = (DONE_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RDY_DLY_CYC   = (RDY_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W         = 8;

   typedef struct packed {
      logic csN;
      logic wrN;
      logic rdN;
      logic mode;
   } bus_ctl_t;

   typedef struct packed {
      logic             timedOut;
      logic [DATA_W-1:0] data;
   } result_t;

endpackage

// File: sync2.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sync2 #(
   parameter int unsigned W = 1
) (
   input  wire logic         sys_clk, // System clock
   input  wire logic         rst_n,   // Synchronous reset, low active
   input  wire logic [W-1:0] din,     // Asynchronous inputs
   output logic      [W-1:0] dout     // Synchronised outputs
);
   logic [W-1:0] stage1;
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_dout;

   always_comb
   begin
      next_stage1 = din;
      next_dout   = stage1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         stage1 <= '0;
         dout   <= '0;
      end
      else
      begin
         stage1 <= next_stage1;
         dout   <= next_dout;
      end
   end
endmodule
